// ### verification/clk_regs_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ********
// Port checks of the clock register block.
// ********
module clk_regs_monitor (
    // Clock and reset.
    input wire logic        clk,
    input wire logic        rst,
    // Bus handshakes.
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    // Clock side.
    input wire logic        dco_tick,
    input wire logic        xt2_tick,
    input wire logic        lf_tick,
    input wire logic        nmi_grant,
    input wire logic        main_clock_en,
    input wire logic        sub_system_clock_en,
    input wire logic        osc_fault_irq,
    input wire logic [1:0]  crystal_load_cap_sel
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    wire any_tick = dco_tick | xt2_tick | lf_tick;
    chk_r_after_ar: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    chk_r_holds: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
    chk_r_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read bits set");
    chk_b_holds: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
    chk_main_single:
        assert property (main_clock_en |=> !main_clock_en) else $error("main pulse too long");
    chk_main_tick:
        assert property (main_clock_en |-> $past(any_tick) || $past(any_tick, 2))
        else $error("main pulse without source edge");
    chk_sub_single:
        assert property (sub_system_clock_en |=> !sub_system_clock_en)
        else $error("sub pulse too long");
    chk_grant_irq:
        assert property (nmi_grant |=> !osc_fault_irq [*2]) else $error("irq after grant");
    chk_reset_cap:
        assert property ($fell(rst) |-> crystal_load_cap_sel == 2'h1 && !osc_fault_irq)
        else $error("bad reset outputs");
    cover property (nmi_grant && osc_fault_irq);
    cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
    cover property (main_clock_en ##2 main_clock_en);
endmodule
bind clock_source_select_fault_regs clk_regs_monitor u_mon (.clk(clk), .rst(rst),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .dco_tick(dco_tick), .xt2_tick(xt2_tick), .lf_tick(lf_tick), .nmi_grant(nmi_grant),
    .main_clock_en(main_clock_en), .sub_system_clock_en(sub_system_clock_en),
    .osc_fault_irq(osc_fault_irq), .crystal_load_cap_sel(crystal_load_cap_sel));
`default_nettype wire

// ### verification/osc_model.sv
`timescale 1ns/1ps
`default_nettype none
// ********
// Three free-running sources, seen as tick pulses.
// ********
module osc_model (
    // Clock and reset.
    input  wire logic clk,
    input  wire logic rst,
    // Fault control.
    input  wire logic lf_fail,
    // Ticks and health.
    output logic      dco_tick,
    output logic      xt2_tick,
    output logic      lf_tick,
    output logic      lf_bad
);
    logic [4:0] cnt_q;
    // A count of 30 holds whole periods of 2, 3 and 5, so no tick doubles at the wrap.
    always @(posedge clk) begin
        if (rst)
            cnt_q <= 5'h00;
        else
            cnt_q <= (cnt_q == 5'h1D) ? 5'h00 : cnt_q + 5'h01;
    end
    assign dco_tick = !rst && cnt_q[0];
    assign xt2_tick = !rst && (cnt_q % 5'h03) == 5'h00;
    // A failed crystal stops swinging, so its ticks stop while it reports bad.
    assign lf_tick  = !rst && !lf_fail && (cnt_q % 5'h05) == 5'h00;
    assign lf_bad   = lf_fail;
endmodule
`default_nettype wire

// ### verification/tb_clock_source_select_fault_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "clock_select_defs.vh"
// ********
// Self-checking bench.
// ********
module tb_clock_source_select_fault_regs;
    logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
    logic [31:0] wdata = 32'h0, v;
    logic        clk = 1'b0, rst = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0, pres = 1'b1, xbad = 1'b0, lfail = 1'b0;
    logic        hmode = 1'b0, grant = 1'b0, lon = 1'b1;
    wire logic   awready, wready, bvalid, arready, rvalid, dtk, xtk, ltk, lbad;
    wire logic   men, sen, dres, vlo, irq;
    wire logic [1:0]  bresp, rresp, xrng, lrng, cap;
    wire logic [31:0] rdata;
    logic [7:0]  d;
    logic [1:0]  r;
    int          n_fail = 0, checked = 0, g;
    always #20 clk = ~clk;
    clock_source_select_fault_regs DUT (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .xt2_present(pres), .xt2_on(pres), .xt2_bad(xbad),
        .lf_on(lon), .lf_bad(lbad), .low_freq_high_mode_sel(hmode), .dco_tick(dtk),
        .xt2_tick(xtk), .lf_tick(ltk), .nmi_grant(grant), .main_clock_en(men),
        .sub_system_clock_en(sen), .dco_resistor_sel(dres), .second_crystal_range(xrng),
        .low_freq_source_range(lrng), .low_freq_vlo_sel(vlo), .crystal_load_cap_sel(cap),
        .osc_fault_irq(irq));
    osc_model osc (.clk(clk), .rst(rst), .lf_fail(lfail), .dco_tick(dtk),
        .xt2_tick(xtk), .lf_tick(ltk), .lf_bad(lbad));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task wrap_up;
        if (n_fail == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task wr(input logic [3:0] a, input logic [7:0] dd, input logic [3:0] s);
        awaddr <= a;
        wdata <= {24'h0, dd};
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        r = bresp;
        bready <= 1'b0;
        @(posedge clk);
    endtask
    task rd(input logic [3:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        v = rdata;
        r = rresp;
        rready <= 1'b0;
        @(posedge clk);
    endtask
    // Gap between enable pulses; the first pulses after a change may still be settling.
    task gapm(input logic w);
        repeat (3) do @(posedge clk); while (!(w ? sen : men));
        g = 0;
        do begin
            @(posedge clk);
            g++;
        end while (!(w ? sen : men));
    endtask
    // Tick periods of the model: DCO 2, second crystal 3, low-frequency source 5.
    function automatic int fp(input logic [1:0] c, input logic p);
        if (c < 2'h2) return 2;
        return (c == 2'h2 && p) ? 3 : 5;
    endfunction
    task rst_chk;
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(`ADDR_SRC_DIV_CTRL); chk(v, 32'h00);
        rd(`ADDR_OSC_RANGE_CTRL); chk(v, 32'h04);
        rd(`ADDR_INT_FLAG); chk(v, 32'h02);
    endtask
    initial begin
        v = $urandom(32'h97a07238);
        rst_chk;
        for (int i = 0; i < 4; i++) begin
            d = $urandom & 8'hFD;
            wr(i[0] ? `ADDR_INT_FLAG : `ADDR_INT_ENABLE, d, 4'hF);
            rd(i[0] ? `ADDR_INT_FLAG : `ADDR_INT_ENABLE); chk(v, {24'h0, d});
        end
        wr(4'h6, 8'hFF, 4'hF); chk(r, `RESP_SLVERR);
        rd(4'h6); chk(r, `RESP_SLVERR);
        chk(v, 32'h0);
        for (int i = 0; i < 8; i++) begin
            d = $urandom;
            if (i[0] || d[5:4] == 2'h3) d[3:2] = 2'h0;
            hmode <= i[0];
            wr(`ADDR_OSC_RANGE_CTRL, d, 4'h1);
            repeat (2) @(posedge clk);
            rd(`ADDR_OSC_RANGE_CTRL); chk(v, {24'h0, d[7:2], 2'h0});
            chk({xrng, cap}, {d[7:6], d[3:2]});
            chk({lrng, vlo}, {i[0] ? d[5:4] : 2'h0, !i[0] && d[5:4] == 2'h2});
        end
        wr(`ADDR_OSC_RANGE_CTRL, ~d, 4'h0); chk(r, `RESP_OKAY);
        rd(`ADDR_OSC_RANGE_CTRL); chk(v, {24'h0, d[7:2], 2'h0});
        wr(`ADDR_SRC_DIV_CTRL, 8'hC0, 4'hF);
        lfail <= 1'b1;
        xbad <= 1'b1;
        repeat (4) @(posedge clk);
        rd(`ADDR_OSC_RANGE_CTRL); chk(v[1:0], 2'h3);
        rd(`ADDR_INT_FLAG); chk(v[1], 1'b1);
        gapm(1'b0); chk(g, 2);
        rd(`ADDR_SRC_DIV_CTRL); chk(v, 32'hC0);
        rd(`ADDR_INT_ENABLE);
        wr(`ADDR_INT_ENABLE, v[7:0] | 8'h02, 4'hF);
        repeat (2) @(posedge clk);
        chk(irq, 1'b1);
        grant <= 1'b1;
        @(posedge clk);
        grant <= 1'b0;
        repeat (2) @(posedge clk);
        chk(irq, 1'b0);
        rd(`ADDR_INT_ENABLE); chk(v[1], 1'b0);
        rd(`ADDR_INT_FLAG); chk(v[1], 1'b1);
        lfail <= 1'b0;
        xbad <= 1'b0;
        repeat (4) @(posedge clk);
        rd(`ADDR_OSC_RANGE_CTRL); chk(v[1:0], 2'h0);
        rd(`ADDR_INT_FLAG); chk(v[1], 1'b1);
        wr(`ADDR_INT_FLAG, v[7:0] & 8'hFD, 4'hF);
        rd(`ADDR_INT_FLAG); chk(v[1], 1'b0);
        gapm(1'b0); chk(g, 5);
        for (int i = 0; i < 32; i++) begin
            d = $urandom;
            d[7:4] = i[3:0];
            pres <= i[4];
            wr(`ADDR_SRC_DIV_CTRL, d, 4'hF);
            gapm(1'b0); chk(g, fp(d[7:6], i[4]) << d[5:4]);
            gapm(1'b1); chk(g, fp({d[3], 1'b0}, i[4]) << d[2:1]);
            chk(dres, d[0]);
        end
        lon <= 1'b0;
        lfail <= 1'b1;
        repeat (4) @(posedge clk);
        rd(`ADDR_OSC_RANGE_CTRL); chk(v[0], 1'b0);
        lfail <= 1'b0;
        lon <= 1'b1;
        rst_chk;
        wrap_up;
    end
    initial begin
        repeat (60000) @(posedge clk);
        n_fail++;
        wrap_up;
    end
endmodule
`default_nettype wire

// ### verilog/clock_select_defs.vh
`ifndef CLOCK_SELECT_DEFS_VH
`define CLOCK_SELECT_DEFS_VH

// ****************************************************************
// Register byte addresses on the AXI4-Lite slave.
// ****************************************************************
`define ADDR_SRC_DIV_CTRL   4'h0
`define ADDR_OSC_RANGE_CTRL 4'h4
`define ADDR_INT_ENABLE     4'h8
`define ADDR_INT_FLAG       4'hC

// ****************************************************************
// Field positions.
// ****************************************************************
`define MAIN_SEL_HI   7
`define MAIN_SEL_LO   6
`define MAIN_DIV_HI   5
`define MAIN_DIV_LO   4
`define SUB_SEL_BIT   3
`define SUB_DIV_HI    2
`define SUB_DIV_LO    1
`define DCO_RES_BIT   0
`define XT2_RANGE_HI  7
`define XT2_RANGE_LO  6
`define LF_SRC_HI     5
`define LF_SRC_LO     4
`define CAP_HI        3
`define CAP_LO        2
`define XT2_FAULT_BIT 1
`define LF_FAULT_BIT  0
`define OSC_FAULT_BIT 1

// ****************************************************************
// Reset values.
// ****************************************************************
`define SRC_DIV_RESET   8'h00
`define RANGE_RESET     6'h01
`define INT_REG_RESET   8'h00
`define OSC_FLAG_RESET  1'b1

// ****************************************************************
// Source codes and bus responses.
// ****************************************************************
`define SRC_DCO    2'h0
`define SRC_XT2    2'h1
`define SRC_LF     2'h2
`define RESP_OKAY  2'h0
`define RESP_SLVERR 2'h2

`endif

// ### verilog/clock_source_select_fault_regs.v
// Added by the designer: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "clock_select_defs.vh"

module clock_source_select_fault_regs (
    // Clock and reset.
    input  wire        clk,
    input  wire        rst,
    // AXI4-Lite write channels.
    input  wire [3:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // AXI4-Lite read channels.
    input  wire [3:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // Oscillator side.
    input  wire        xt2_present,
    input  wire        xt2_on,
    input  wire        xt2_bad,
    input  wire        lf_on,
    input  wire        lf_bad,
    input  wire        low_freq_high_mode_sel,
    input  wire        dco_tick,
    input  wire        xt2_tick,
    input  wire        lf_tick,
    input  wire        nmi_grant,
    // Clock outputs and configuration.
    output reg         main_clock_en,
    output reg         sub_system_clock_en,
    output reg         dco_resistor_sel,
    output reg  [1:0]  second_crystal_range,
    output reg  [1:0]  low_freq_source_range,
    output reg         low_freq_vlo_sel,
    output reg  [1:0]  crystal_load_cap_sel,
    output reg         osc_fault_irq
);

    // ****************************************************************
    // Register state.
    // ****************************************************************
    reg [7:0] src_div_q;
    reg [5:0] range_q;
    reg [7:0] ie_q;
    reg [7:0] ifg_q;
    reg       xt2_fault_q;
    reg       lf_fault_q;
    reg       aw_hold_q;
    reg [3:0] aw_addr_q;
    reg       w_hold_q;
    reg [7:0] w_data_q;
    reg       w_strb_q;

    wire      xt2_fault_now = xt2_on & xt2_bad;
    wire      lf_fault_now  = lf_on & lf_bad;
    wire      do_write      = aw_hold_q & w_hold_q & ~s_axi_bvalid;
    wire      write_hit     = (aw_addr_q == `ADDR_SRC_DIV_CTRL) |
                              (aw_addr_q == `ADDR_OSC_RANGE_CTRL) |
                              (aw_addr_q == `ADDR_INT_ENABLE) |
                              (aw_addr_q == `ADDR_INT_FLAG);

    // Maps a source select code to the underlying tick.
    function pick_tick;
        input [1:0] code;
        input       dco;
        input       xt2;
        input       lf;
        begin
            case (code)
                `SRC_DCO: pick_tick = dco;
                `SRC_XT2: pick_tick = xt2;
                default:  pick_tick = lf;
            endcase
        end
    endfunction

    // Decodes a crystal source choice into a source code.
    function [1:0] crystal_code;
        input has_xt2;
        begin
            crystal_code = has_xt2 ? `SRC_XT2 : `SRC_LF;
        end
    endfunction

    // Divide-by-1/2/4/8 enable from a free counter.
    function div_hit;
        input [1:0] code;
        input [2:0] cnt;
        begin
            case (code)
                2'h0:    div_hit = 1'b1;
                2'h1:    div_hit = cnt[0];
                2'h2:    div_hit = &cnt[1:0];
                default: div_hit = &cnt;
            endcase
        end
    endfunction

    // ****************************************************************
    // AXI4-Lite write path.
    // ****************************************************************
    always @(posedge clk) begin
        if (rst) begin
            aw_hold_q     <= 1'b0;
            aw_addr_q     <= 4'h0;
            w_hold_q      <= 1'b0;
            w_data_q      <= 8'h00;
            w_strb_q      <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RESP_OKAY;
        end else begin
            s_axi_awready <= ~aw_hold_q & ~s_axi_awready & s_axi_awvalid;
            s_axi_wready  <= ~w_hold_q & ~s_axi_wready & s_axi_wvalid;
            if (s_axi_awvalid & s_axi_awready) begin
                aw_hold_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                w_hold_q <= 1'b1;
                w_data_q <= s_axi_wdata[7:0];
                w_strb_q <= s_axi_wstrb[0];
            end
            if (do_write) begin
                aw_hold_q    <= 1'b0;
                w_hold_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= write_hit ? `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_bvalid & s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Control, enable and flag registers.
    // ****************************************************************
    always @(posedge clk) begin
        if (rst) begin
            src_div_q   <= `SRC_DIV_RESET;
            range_q     <= `RANGE_RESET;
            ie_q        <= `INT_REG_RESET;
            ifg_q       <= `INT_REG_RESET;
            ifg_q[`OSC_FAULT_BIT] <= `OSC_FLAG_RESET;
            xt2_fault_q <= 1'b0;
            lf_fault_q  <= 1'b1;
        end else begin
            xt2_fault_q <= xt2_fault_now;
            lf_fault_q  <= lf_fault_now;
            if (do_write & w_strb_q) begin
                case (aw_addr_q)
                    `ADDR_SRC_DIV_CTRL:   src_div_q <= w_data_q;
                    // Fault bits are not stored from the bus.
                    `ADDR_OSC_RANGE_CTRL: range_q <= w_data_q[7:2];
                    `ADDR_INT_ENABLE:     ie_q <= w_data_q;
                    `ADDR_INT_FLAG:       ifg_q <= w_data_q;
                    default:              ;
                endcase
            end
            // Grant clears the enable, but the flag stays for software.
            if (nmi_grant)
                ie_q[`OSC_FAULT_BIT] <= 1'b0;
            // A fault in the same cycle as a software clear wins.
            if (xt2_fault_now | lf_fault_now)
                ifg_q[`OSC_FAULT_BIT] <= 1'b1;
        end
    end

    // ****************************************************************
    // AXI4-Lite read path.
    // ****************************************************************
    always @(posedge clk) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `RESP_OKAY;
        end else begin
            s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
            if (s_axi_arvalid & s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= `RESP_OKAY;
                case (s_axi_araddr)
                    `ADDR_SRC_DIV_CTRL:   s_axi_rdata <= {24'h000000, src_div_q};
                    `ADDR_OSC_RANGE_CTRL: s_axi_rdata <= {24'h000000, range_q,
                                                          xt2_fault_q, lf_fault_q};
                    `ADDR_INT_ENABLE:     s_axi_rdata <= {24'h000000, ie_q};
                    `ADDR_INT_FLAG:       s_axi_rdata <= {24'h000000, ifg_q};
                    default: begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= `RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rvalid & s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Source selection and glitch-free switching.
    // ****************************************************************
    reg  [1:0] main_cur_q;
    reg        main_wait_q;
    reg  [1:0] sub_cur_q;
    reg        sub_wait_q;
    reg  [2:0] main_cnt_q;
    reg  [2:0] sub_cnt_q;
    reg  [1:0] main_want;
    reg        main_crystal;
    wire [1:0] sub_want;
    wire       main_fault;
    wire       main_tick;
    wire       sub_tick;

    always @* begin
        main_crystal = 1'b0;
        case (src_div_q[`MAIN_SEL_HI:`MAIN_SEL_LO])
            2'h0, 2'h1: main_want = `SRC_DCO;
            2'h2: begin
                main_want    = crystal_code(xt2_present);
                main_crystal = 1'b1;
            end
            default: begin
                main_want    = `SRC_LF;
                main_crystal = 1'b1;
            end
        endcase
    end

    // A crystal in fault drops the main clock to the DCO; stored bits stay.
    assign main_fault = main_crystal &
                        ((main_want == `SRC_XT2) ? xt2_fault_now : lf_fault_now);
    assign sub_want   = src_div_q[`SUB_SEL_BIT] ? crystal_code(xt2_present)
                                                : `SRC_DCO;
    assign main_tick  = pick_tick(main_cur_q, dco_tick, xt2_tick, lf_tick);
    assign sub_tick   = pick_tick(sub_cur_q, dco_tick, xt2_tick, lf_tick);

    // On a change the old source ends its cycle (a main-clock fault skips this), the output is held
    // until the new source ticks, and then that source takes over.
    always @(posedge clk) begin
        if (rst) begin
            main_cur_q          <= `SRC_DCO;
            main_wait_q         <= 1'b0;
            sub_cur_q           <= `SRC_DCO;
            sub_wait_q          <= 1'b0;
            main_cnt_q          <= 3'h0;
            sub_cnt_q           <= 3'h0;
            main_clock_en       <= 1'b0;
            sub_system_clock_en <= 1'b0;
        end else begin
            main_clock_en       <= 1'b0;
            sub_system_clock_en <= 1'b0;
            if (main_wait_q) begin
                if (pick_tick(main_fault ? `SRC_DCO : main_want,
                              dco_tick, xt2_tick, lf_tick)) begin
                    main_cur_q  <= main_fault ? `SRC_DCO : main_want;
                    main_wait_q <= 1'b0;
                end
            end else if ((main_fault ? `SRC_DCO : main_want) != main_cur_q) begin
                main_wait_q <= main_tick | main_fault;
            end else if (main_tick) begin
                main_cnt_q    <= main_cnt_q + 3'h1;
                main_clock_en <= div_hit(src_div_q[`MAIN_DIV_HI:`MAIN_DIV_LO],
                                         main_cnt_q);
            end
            if (sub_wait_q) begin
                if (pick_tick(sub_want, dco_tick, xt2_tick, lf_tick)) begin
                    sub_cur_q  <= sub_want;
                    sub_wait_q <= 1'b0;
                end
            end else if (sub_want != sub_cur_q) begin
                sub_wait_q <= sub_tick;
            end else if (sub_tick) begin
                sub_cnt_q           <= sub_cnt_q + 3'h1;
                sub_system_clock_en <= div_hit(src_div_q[`SUB_DIV_HI:`SUB_DIV_LO],
                                               sub_cnt_q);
            end
        end
    end

    // ****************************************************************
    // Configuration outputs and interrupt.
    // ****************************************************************
    always @(posedge clk) begin
        if (rst) begin
            dco_resistor_sel      <= 1'b0;
            second_crystal_range  <= 2'h0;
            low_freq_source_range <= 2'h0;
            low_freq_vlo_sel      <= 1'b0;
            crystal_load_cap_sel  <= 2'h1;
            osc_fault_irq         <= 1'b0;
        end else begin
            dco_resistor_sel      <= src_div_q[`DCO_RES_BIT];
            second_crystal_range  <= range_q[5:4];
            // Range code only counts in high mode, source choice in low mode.
            low_freq_source_range <= low_freq_high_mode_sel ? range_q[3:2] : 2'h0;
            low_freq_vlo_sel      <= ~low_freq_high_mode_sel &
                                     (range_q[3:2] == 2'h2);
            crystal_load_cap_sel  <= range_q[1:0];
            osc_fault_irq         <= ie_q[`OSC_FAULT_BIT] & ifg_q[`OSC_FAULT_BIT] &
                                     ~nmi_grant;
        end
    end

endmodule

`default_nettype wire
